// File: wor_pkg.sv
// package: offsets, layout and reset values for the write-once option register
package wor_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SETUP_WORD_IDX     = 12'h01D;
    localparam logic [11:0] SETUP_WORD_ADDR    = {SETUP_WORD_IDX[9:0], 2'h0};
    localparam int          TRIG_SEL_BIT       = 1;
    localparam int          WDOG_EN_BIT        = 0;
    localparam int          STOP_EN_BIT        = 2;
    localparam logic [7:0]  SETUP_WORD_RST     = 8'h04;
    localparam logic [1:0]  AXI_OKAY           = 2'h0;
    localparam logic [1:0]  AXI_SLVERR         = 2'h2;

    typedef struct packed {
        logic ext_int_trigger_select;
        logic watchdog_enable;
    } wor_opts_s;
endpackage : wor_pkg

// File: wor_setup_word.sv
// write-once option register with an axi4-lite slave port
`timescale 1ns/1ps
// ------------------------------------------------------------
// Functional notes
// - one software write accepted after each reset; reads allowed any time
// - trigger select 1 means edge only, 0 means edge and level
// - watchdog enable 1 runs the watchdog, 0 stops it
// - reset clears both option bits; low three bits read 100
// - register at 0x1D; trigger select bit 1, watchdog enable bit 0
// - stop instruction option fixed at manufacture, software cannot change it
// ------------------------------------------------------------
module wor_setup_word #(
    parameter bit STOP_ENABLED = 1'b1
) (
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_ce,
    input  wire logic [11:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [11:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output wor_pkg::wor_opts_s       o_opts,
    output logic                     o_stop_enable,
    output logic                     o_locked
);
    import wor_pkg::*;

    function automatic logic hit(input logic [11:0] a);
        hit = (a[11:2] == SETUP_WORD_ADDR[11:2]);
    endfunction : hit

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic        aw_q;
    logic        w_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        trig_q;
    logic        wdog_q;
    logic        locked_q;
    logic        do_wr;

    // ready falls with the enable so a frozen slave never completes a handshake
    assign s_axi_awready = i_ce && !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = i_ce && !w_q && !s_axi_bvalid;
    assign do_wr         = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            aw_q     <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (i_ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            w_q     <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (i_ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (i_ce) begin
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= hit(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // option bits
    // ------------------------------------------------------------
    // a write with lane 0 off still spends the single write: software
    // only gets one try, whatever it carried
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            trig_q   <= SETUP_WORD_RST[TRIG_SEL_BIT];
            wdog_q   <= SETUP_WORD_RST[WDOG_EN_BIT];
            locked_q <= 1'b0;
        end else if (i_ce && do_wr && hit(awaddr_q) && !locked_q) begin
            locked_q <= 1'b1;
            if (wstrb_q[0]) begin
                trig_q <= wdata_q[TRIG_SEL_BIT];
                wdog_q <= wdata_q[WDOG_EN_BIT];
            end
        end
    end

    assign o_opts.ext_int_trigger_select = trig_q;
    assign o_opts.watchdog_enable        = wdog_q;
    assign o_stop_enable                 = STOP_ENABLED;
    assign o_locked                      = locked_q;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = i_ce && !s_axi_rvalid;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_OKAY;
        end else if (i_ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (hit(s_axi_araddr)) begin
                    s_axi_rdata <= {29'h0, STOP_ENABLED, trig_q, wdog_q};
                    s_axi_rresp <= AXI_OKAY;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AXI_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_reset_clears: assert property ($fell(i_sys_rst) |-> !trig_q && !wdog_q && !locked_q)
        else $error("option bits not cleared by reset");
    a_locked_hold: assert property (locked_q |=> $stable(trig_q) && $stable(wdog_q))
        else $error("option bits changed after lock");
    a_lock_sticky: assert property (locked_q |=> locked_q)
        else $error("lock dropped without reset");
    a_first_write: assert property (i_ce && do_wr && hit(awaddr_q) && !locked_q
        && wstrb_q[0] |=> trig_q == $past(wdata_q[1]) && wdog_q == $past(wdata_q[0]))
        else $error("first write not stored");
    a_read_value: assert property (i_ce && s_axi_arvalid && s_axi_arready
        && hit(s_axi_araddr) |=> s_axi_rvalid && s_axi_rdata[1:0] == $past({trig_q, wdog_q}))
        else $error("read data wrong");
    a_trig_out: assert property (!(i_ce && do_wr && hit(awaddr_q) && !locked_q)
        |=> $stable(o_opts.ext_int_trigger_select))
        else $error("trigger select moved without the first write");
    a_wdog_out: assert property (!(i_ce && do_wr && hit(awaddr_q) && !locked_q)
        |=> $stable(o_opts.watchdog_enable))
        else $error("watchdog enable moved without the first write");
    a_stop_fixed: assert property (o_stop_enable == STOP_ENABLED && s_axi_rvalid
        && s_axi_rresp == AXI_OKAY |-> s_axi_rdata[STOP_EN_BIT] == STOP_ENABLED)
        else $error("stop option not fixed");
    a_write_resp: assert property (i_ce && do_wr |=> s_axi_bvalid)
        else $error("write response missing");

    // ------------------------------------------------------------
    // write channel checks
    // ------------------------------------------------------------
    a_aw_capture: assert property (i_ce && s_axi_awvalid && s_axi_awready
        |=> aw_q && awaddr_q == $past(s_axi_awaddr))
        else $error("write address not captured");
    a_awaddr_hold: assert property (aw_q && !(i_ce && do_wr)
        |=> $stable(awaddr_q))
        else $error("held write address changed");
    a_w_capture: assert property (i_ce && s_axi_wvalid && s_axi_wready
        |=> w_q && wdata_q == $past(s_axi_wdata) && wstrb_q == $past(s_axi_wstrb))
        else $error("write data not captured");
    a_wdata_hold: assert property (w_q && !(i_ce && do_wr)
        |=> $stable(wdata_q) && $stable(wstrb_q))
        else $error("held write data changed");
    a_aw_wait: assert property (aw_q && !w_q
        |=> aw_q)
        else $error("write address lost before its data");
    a_w_wait: assert property (w_q && !aw_q
        |=> w_q)
        else $error("write data lost before its address");
    a_pair_clears: assert property (i_ce && do_wr
        |=> !aw_q && !w_q)
        else $error("write pair not released");
    a_bvalid_cause: assert property ($rose(s_axi_bvalid)
        |-> $past(i_ce && do_wr))
        else $error("write response without a write");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> $stable(s_axi_bresp))
        else $error("write response code changed while waiting");
    a_resp_done: assert property (i_ce && s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write response not retired");
    a_aw_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while a response waits");
    a_bresp_legal: assert property (s_axi_bvalid
        |-> s_axi_bresp == AXI_OKAY || s_axi_bresp == AXI_SLVERR)
        else $error("illegal write response code");
    a_miss_no_lock: assert property (i_ce && do_wr && !hit(awaddr_q)
        |=> s_axi_bresp == AXI_SLVERR && $stable(locked_q))
        else $error("unmapped write not refused");
    a_hit_okay: assert property (i_ce && do_wr && hit(awaddr_q)
        |=> s_axi_bresp == AXI_OKAY && locked_q)
        else $error("register write not answered okay");

    // ------------------------------------------------------------
    // option bit checks
    // ------------------------------------------------------------
    // a write with lane 0 off still answers okay; only the lock shows that it was spent
    a_lock_cause: assert property ($rose(locked_q)
        |-> $past(i_ce && do_wr && hit(awaddr_q)))
        else $error("lock set without a register write");
    a_late_write_ignored: assert property (i_ce && do_wr && locked_q
        |=> $stable(trig_q) && $stable(wdog_q))
        else $error("write after the first changed the options");
    a_strobe_spent: assert property (i_ce && do_wr && hit(awaddr_q) && !locked_q
        && !wstrb_q[0] |=> locked_q && $stable(trig_q) && $stable(wdog_q))
        else $error("write without lane 0 handled wrongly");

    // ------------------------------------------------------------
    // read channel checks
    // ------------------------------------------------------------
    a_rvalid_cause: assert property ($rose(s_axi_rvalid)
        |-> $past(i_ce && s_axi_arvalid && s_axi_arready))
        else $error("read data without a read request");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid)
        else $error("read data dropped before rready");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed while waiting");
    a_read_done: assert property (i_ce && s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid)
        else $error("read data not retired");
    a_ar_blocked: assert property (s_axi_rvalid
        |-> !s_axi_arready)
        else $error("read accepted while data waits");
    a_rresp_legal: assert property (s_axi_rvalid
        |-> s_axi_rresp == AXI_OKAY || s_axi_rresp == AXI_SLVERR)
        else $error("illegal read response code");
    a_read_miss: assert property (i_ce && s_axi_arvalid && s_axi_arready
        && !hit(s_axi_araddr) |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_read_stop: assert property (i_ce && s_axi_arvalid && s_axi_arready
        && hit(s_axi_araddr) |=> s_axi_rresp == AXI_OKAY && s_axi_rdata[STOP_EN_BIT] == STOP_ENABLED)
        else $error("register read not answered with the stop option");
    a_read_upper: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:3] == 29'h0000_0000)
        else $error("unused read bits not zero");

    // ------------------------------------------------------------
    // enable and reset checks
    // ------------------------------------------------------------
    // the reset overrides the enable, so the default disable covers both
    a_ce_freeze: assert property (!i_ce
        |=> $stable(locked_q) && $stable(trig_q) && $stable(wdog_q))
        else $error("option state moved while the enable was low");
    a_ce_no_take: assert property (!i_ce
        |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready shown while the enable was low");
    a_ce_hold_valid: assert property (!i_ce
        |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
        else $error("response valid moved while the enable was low");
    a_reset_out: assert property ($fell(i_sys_rst)
        |-> !s_axi_bvalid && !s_axi_rvalid && !aw_q && !w_q && o_opts == '0)
        else $error("bus state not cleared by reset");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_first_write: cover property (do_wr && !locked_q ##1 locked_q);
    c_second_write: cover property (locked_q && do_wr && hit(awaddr_q));
    c_read_back: cover property (s_axi_rvalid && s_axi_rready && locked_q);
    c_refused_write: cover property (do_wr && !hit(awaddr_q));
    c_ce_stall: cover property (!i_ce && s_axi_awvalid);
endmodule : wor_setup_word

// File: wor_setup_word_tb.sv
// self-checking testbench for the write-once option register
`timescale 1ns/1ps
module wor_setup_word_tb;
    import wor_pkg::*;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    wor_opts_s   o_opts;
    logic        o_stop_enable, o_locked;
    int          n_fail = 0, num_checks = 0, i;
    // ------------------------------------------------------------
    // rows: written word beside the word that must read back
    // ------------------------------------------------------------
    logic [31:0] row_wd [4] = '{32'hFFFFFFFF, 32'h00000002, 32'h000000A5, 32'h00000000};
    logic [31:0] row_rd [4] = '{32'h00000007, 32'h00000006, 32'h00000005, 32'h00000004};

    wor_setup_word wor_setup_word_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .o_opts(o_opts),
        .o_stop_enable(o_stop_enable), .o_locked(o_locked));

    initial begin
        forever #25 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // compare, report, reset and bus tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: response %h expected %h", $time, got, exp);
        end
    endtask : chk_resp
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rst_pulse();
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
    endtask : rst_pulse
    // ready is combinational on held inputs, so the negedge value is the one taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rsp);
        logic ta, tw, done;
        done = 1'b0;
        rsp = 2'h3;
        @(posedge i_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 20 && !done; k++) begin
            @(negedge i_clk);
            ta = s_axi_awvalid && (s_axi_awready === 1'b1);
            tw = s_axi_wvalid && (s_axi_wready === 1'b1);
            done = (s_axi_bvalid === 1'b1);
            rsp = s_axi_bresp;
            @(posedge i_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
        if (!done) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rsp);
        logic ta, done;
        done = 1'b0;
        @(posedge i_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 20 && !done; k++) begin
            @(negedge i_clk);
            ta = s_axi_arvalid && (s_axi_arready === 1'b1);
            done = (s_axi_rvalid === 1'b1);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge i_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        if (!done) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : axi_rd
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_pulse();
        axi_rd(SETUP_WORD_ADDR, d, r);
        chk_word(d, 32'h00000004);
        chk_resp(r, AXI_OKAY);
        for (i = 0; i < 4; i++) begin
            rst_pulse();
            // a refused write elsewhere must not spend the single write
            axi_wr(12'h000, row_wd[i], r);
            chk_resp(r, AXI_SLVERR);
            chk_word({31'h0, o_locked}, 32'h0);
            axi_wr(SETUP_WORD_ADDR, row_wd[i], r);
            chk_resp(r, AXI_OKAY);
            chk_word({31'h0, o_locked}, 32'h1);
            chk_word({30'h0, o_opts}, row_rd[i] & 32'h3);
            axi_wr(SETUP_WORD_ADDR, ~row_wd[i], r);
            chk_resp(r, AXI_OKAY);
            axi_rd(SETUP_WORD_ADDR, d, r);
            chk_resp(r, AXI_OKAY);
            chk_word(d, row_rd[i]);
            chk_word({30'h0, o_opts}, row_rd[i] & 32'h3);
        end
        axi_rd(12'h000, d, r);
        chk_resp(r, AXI_SLVERR);
        chk_word(d, 32'h0);
        // awkward: a write with lane 0 off still spends the single write
        rst_pulse();
        s_axi_wstrb <= 4'hE;
        axi_wr(SETUP_WORD_ADDR, 32'h00000003, r);
        chk_resp(r, AXI_OKAY);
        chk_word({29'h0, o_locked, o_opts}, 32'h00000004);
        s_axi_wstrb <= 4'hF;
        // awkward: a low enable holds the write off until it returns
        rst_pulse();
        i_ce <= 1'b0;
        fork
            axi_wr(SETUP_WORD_ADDR, 32'h00000003, r);
            begin
                repeat (6) @(posedge i_clk);
                chk_word({29'h0, o_locked, s_axi_bvalid, s_axi_awready}, 32'h0);
                i_ce <= 1'b1;
            end
        join
        chk_resp(r, AXI_OKAY);
        chk_word({29'h0, o_locked, o_opts}, 32'h00000007);
        rst_pulse();
        chk_word({29'h0, o_stop_enable, o_opts}, 32'h00000004);
        chk_word({31'h0, o_locked}, 32'h0);
        tally_and_finish();
    end
endmodule : wor_setup_word_tb
